// ==== hdl/crlp_pkg.sv ====
// Package with register map, field layout, reset values and ratio tables of the clock and low-power control.
package crlp_pkg;

  // ---------------------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  CTRL_OFFSET      = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET    = 4'h4;
  localparam int          BYPASS_BIT       = 0;
  localparam int          RATIO_LSB        = 9;
  localparam int          RATIO_MSB        = 11;
  localparam int          DEPTH_LSB        = 12;
  localparam int          DEPTH_MSB        = 13;
  localparam logic [2:0]  RATIO_RESET      = 3'h7;
  localparam logic [1:0]  DEPTH_RESET      = 2'h0;
  localparam logic        BYPASS_RESET     = 1'b0;

  // ---------------------------------------------------------------------------
  // Ratio tables: output rate is reference rate times NUM over DEN, code 0 in the lowest nibble, listed last
  // ---------------------------------------------------------------------------
  localparam logic [31:0] RATIO_NUM        = {4'h1, 4'h4, 4'h2, 4'h4, 4'h1, 4'h4, 4'h2, 4'h4};
  localparam logic [31:0] RATIO_DEN        = {4'h2, 4'h7, 4'h3, 4'h5, 4'h1, 4'h3, 4'h1, 4'h1};
  localparam int          REF_DIV_DEFAULT  = 8;

  // ---------------------------------------------------------------------------
  // Sleep states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_LIGHT  = 2'b01,
    ST_MEDIUM = 2'b10,
    ST_HALT   = 2'b11
  } crlp_state_t;

endpackage

// ==== hdl/crlp_ratio_gen.sv ====
// Fractional rate generator that makes the core output clock enable from the reference tick rate.
`timescale 1ns/1ps
module crlp_ratio_gen #(
  parameter int REF_DIV = crlp_pkg::REF_DIV_DEFAULT
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [2:0] ratio,
  output logic            tick_r
);

  // ---------------------------------------------------------------------------
  // Accumulator
  // ---------------------------------------------------------------------------
  // The reference ticks once every REF_DIV clocks, so each clock adds NUM and a
  // pulse is due whenever DEN times REF_DIV has been gathered.
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  wire  [3:0] num   = crlp_pkg::RATIO_NUM[4*ratio +: 4];
  wire  [3:0] den   = crlp_pkg::RATIO_DEN[4*ratio +: 4];
  wire  [7:0] limit = 8'(den * REF_DIV);
  wire  [7:0] sum   = acc_r + {4'h0, num};
  wire        due   = sum >= limit;

  assign acc_nxt = !run ? 8'h00 : (due ? 8'(sum - limit) : sum);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acc_r  <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      tick_r <= run & due;
    end
  end

endmodule

// ==== hdl/crlp_top.sv ====
// Clock ratio and low-power sequencing control with an Avalon-MM register slave.
`timescale 1ns/1ps
module crlp_top #(
  parameter int REF_DIV = crlp_pkg::REF_DIV_DEFAULT
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        idle_exec,
  input  wire logic        periph_irq,
  input  wire logic        ext_irq,
  input  wire logic        wakeup_irq,
  input  wire logic        power_drive_protect_input,
  output logic             core_output_clock,
  output logic             cpu_clk_en,
  output logic             sys_clk_en,
  output logic             watchdog_clock_en,
  output logic             pll_on,
  output logic             osc_on,
  output logic             flash_pwr_on,
  output logic             osc_bypass
);

  // ---------------------------------------------------------------------------
  // Register bus slave
  // ---------------------------------------------------------------------------
  // Every access waits exactly one cycle: waitrequest falls in the cycle after
  // the request appears and rises again at the accepting edge.
  logic        wait_r;
  logic [31:0] rdata_r;
  logic [2:0]  ratio_r;
  logic [1:0]  depth_r;
  logic        bypass_r;

  wire         req        = avs_read | avs_write;
  wire         accept     = req & ~wait_r;
  wire         wr_accept  = avs_write & ~wait_r;
  wire         hit_ctrl   = avs_address == crlp_pkg::CTRL_OFFSET;
  wire         hit_status = avs_address == crlp_pkg::STATUS_OFFSET;
  wire         wr_ctrl_b0 = wr_accept & hit_ctrl & avs_byteenable[0];
  wire         wr_ctrl_b1 = wr_accept & hit_ctrl & avs_byteenable[1];
  wire         wait_nxt   = ~(req & wait_r);

  crlp_pkg::crlp_state_t state_r;
  crlp_pkg::crlp_state_t state_nxt;

  wire  [31:0] ctrl_word  = {18'h0, depth_r, ratio_r, 8'h00, bypass_r};
  wire  [31:0] stat_word  = {24'h0, flash_pwr_on, osc_on, pll_on, watchdog_clock_en,
                             sys_clk_en, cpu_clk_en, state_r};
  wire  [31:0] rdata_nxt  = hit_ctrl   ? ctrl_word :
                            hit_status ? stat_word : 32'h0000_0000;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r  <= wait_nxt;
      if (avs_read && wait_r) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rdata_r;

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  // Fields change only on reset or an accepted write, never on sleep entry or wake.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ratio_r  <= crlp_pkg::RATIO_RESET;
      depth_r  <= crlp_pkg::DEPTH_RESET;
      bypass_r <= crlp_pkg::BYPASS_RESET;
    end else begin
      if (wr_ctrl_b0) begin
        bypass_r <= avs_writedata[crlp_pkg::BYPASS_BIT];
      end
      if (wr_ctrl_b1) begin
        ratio_r <= avs_writedata[crlp_pkg::RATIO_MSB:crlp_pkg::RATIO_LSB];
        depth_r <= avs_writedata[crlp_pkg::DEPTH_MSB:crlp_pkg::DEPTH_LSB];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Protect input synchroniser
  // ---------------------------------------------------------------------------
  // The level is taken only once the second and third stages agree, which
  // filters a single-cycle glitch on the pin.
  logic [2:0] pdp_sync_r;
  logic       pdp_level_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pdp_sync_r  <= 3'h0;
      pdp_level_r <= 1'b0;
    end else begin
      pdp_sync_r <= {pdp_sync_r[1:0], power_drive_protect_input};
      if (pdp_sync_r[1] == pdp_sync_r[2]) begin
        pdp_level_r <= pdp_sync_r[2];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Sleep state machine
  // ---------------------------------------------------------------------------
  // Reset wakes every depth through the asynchronous reset itself.
  wire wake_light  = periph_irq | ext_irq | pdp_level_r;
  wire wake_medium = wakeup_irq | ext_irq | pdp_level_r;
  wire wake_halt   = pdp_level_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      crlp_pkg::ST_RUN: begin
        if (idle_exec) begin
          if (depth_r[1]) begin
            state_nxt = crlp_pkg::ST_HALT;
          end else if (depth_r[0]) begin
            state_nxt = crlp_pkg::ST_MEDIUM;
          end else begin
            state_nxt = crlp_pkg::ST_LIGHT;
          end
        end
      end
      crlp_pkg::ST_LIGHT: begin
        if (wake_light) begin
          state_nxt = crlp_pkg::ST_RUN;
        end
      end
      crlp_pkg::ST_MEDIUM: begin
        if (wake_medium) begin
          state_nxt = crlp_pkg::ST_RUN;
        end
      end
      crlp_pkg::ST_HALT: begin
        if (wake_halt) begin
          state_nxt = crlp_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = crlp_pkg::ST_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Domain and power enables
  // ---------------------------------------------------------------------------
  // Enables follow the next state so they change at the same edge as the state.
  wire run_nxt   = state_nxt == crlp_pkg::ST_RUN;
  wire light_nxt = state_nxt == crlp_pkg::ST_LIGHT;
  wire halt_nxt  = state_nxt == crlp_pkg::ST_HALT;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r           <= crlp_pkg::ST_RUN;
      cpu_clk_en        <= 1'b1;
      sys_clk_en        <= 1'b1;
      watchdog_clock_en <= 1'b1;
      pll_on            <= 1'b1;
      osc_on            <= 1'b1;
      flash_pwr_on      <= 1'b1;
      osc_bypass        <= 1'b0;
    end else begin
      state_r           <= state_nxt;
      cpu_clk_en        <= run_nxt;
      sys_clk_en        <= run_nxt | light_nxt;
      watchdog_clock_en <= ~halt_nxt;
      pll_on            <= ~halt_nxt;
      osc_on            <= ~halt_nxt & ~bypass_r;
      flash_pwr_on      <= ~halt_nxt;
      osc_bypass        <= bypass_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Core output clock
  // ---------------------------------------------------------------------------
  // The PLL runs in every state but halt, so the output clock survives the
  // lighter depths and peripherals on it keep going.
  crlp_ratio_gen #(
    .REF_DIV (REF_DIV)
  ) u_ratio (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .run     (~halt_nxt),
    .ratio   (ratio_r),
    .tick_r  (core_output_clock)
  );

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence idle_from_run_s;
    state_r == crlp_pkg::ST_RUN && idle_exec;
  endsequence

  sequence halt_no_protect_s;
    state_r == crlp_pkg::ST_HALT && !pdp_level_r;
  endsequence

  ratio_held_a: assert property (!wr_ctrl_b1 |=> $stable(ratio_r) && $stable(depth_r))
    else $error("Control fields changed without a write.");

  idle_cpu_stop_a: assert property (idle_from_run_s |=> !cpu_clk_en && osc_bypass == $past(bypass_r))
    else $error("CPU clock kept running after idle.");

  depth_pick_a: assert property (idle_from_run_s |=> state_r == ($past(depth_r[1]) ? crlp_pkg::ST_HALT :
      ($past(depth_r[0]) ? crlp_pkg::ST_MEDIUM : crlp_pkg::ST_LIGHT)))
    else $error("Wrong sleep depth entered.");

  light_sys_on_a: assert property (state_r == crlp_pkg::ST_LIGHT |-> sys_clk_en && !cpu_clk_en
      && watchdog_clock_en && pll_on && flash_pwr_on)
    else $error("Light sleep enables wrong.");

  medium_stop_a: assert property (state_r == crlp_pkg::ST_MEDIUM |-> !sys_clk_en && !cpu_clk_en
      && watchdog_clock_en && pll_on && flash_pwr_on)
    else $error("Medium sleep enables wrong.");

  halt_power_a: assert property (state_r == crlp_pkg::ST_HALT |-> !watchdog_clock_en && !pll_on
      && !osc_on && !flash_pwr_on && !sys_clk_en)
    else $error("Halt left a clock or supply on.");

  halt_out_clk_a: assert property (state_r == crlp_pkg::ST_HALT |=> !core_output_clock)
    else $error("Core output clock ticked in halt.");

  run_all_on_a: assert property (state_r == crlp_pkg::ST_RUN |-> cpu_clk_en && sys_clk_en
      && watchdog_clock_en && pll_on && flash_pwr_on && osc_on == !osc_bypass)
    else $error("Running state lost an enable.");

  halt_stays_a: assert property (halt_no_protect_s |=> state_r == crlp_pkg::ST_HALT)
    else $error("Halt left without protect input.");

  light_wake_a: assert property (state_r == crlp_pkg::ST_LIGHT && periph_irq |=>
      state_r == crlp_pkg::ST_RUN ##0 cpu_clk_en)
    else $error("Light sleep ignored a peripheral interrupt.");

  medium_ignore_a: assert property (state_r == crlp_pkg::ST_MEDIUM && !wakeup_irq && !ext_irq
      && !pdp_level_r |=> state_r == crlp_pkg::ST_MEDIUM)
    else $error("Medium sleep woke without a valid source.");

  // A ratio change may leave the accumulator above the new limit for a few cycles, so the
  // half-rate spacing is only checked once the ratio has been still for eight cycles.
  half_rate_a: assert property ($stable(ratio_r) [*8] ##0 (ratio_r == 3'h7 && state_r == crlp_pkg::ST_RUN
      && core_output_clock) |=> !core_output_clock)
    else $error("Output clock faster than half reference at reset ratio.");

  bus_answer_a: assert property (req && wait_r |=> !avs_waitrequest)
    else $error("Bus access not answered in one cycle.");

endmodule

// ==== testbench/crlp_cpu_model.sv ====
// CPU core model that issues the idle instruction and drives the wake sources.
`timescale 1ns/1ps
module crlp_cpu_model (
  input  wire logic ref_clk,
  output logic      idle_exec,
  output logic      periph_irq,
  output logic      ext_irq,
  output logic      wakeup_irq,
  output logic      power_drive_protect_input
);
  initial begin
    idle_exec = 1'b0;
    {power_drive_protect_input, wakeup_irq, ext_irq, periph_irq} = 4'h0;
  end
  // One-cycle idle pulse, launched and dropped just after rising edges.
  task automatic issue_idle();
    @(posedge ref_clk) idle_exec <= 1'b1;
    @(posedge ref_clk) idle_exec <= 1'b0;
  endtask
  // Wake levels as {protect, wakeup, ext, periph}; they stay until changed.
  task automatic set_wake(input logic [3:0] v);
    @(posedge ref_clk) {power_drive_protect_input, wakeup_irq, ext_irq, periph_irq} <= v;
  endtask
endmodule

// ==== testbench/tb_crlp_top.sv ====
// Self-checking testbench for the clock ratio and low-power control.
`timescale 1ns/1ps
module tb_crlp_top;
  logic        ref_clk;
  logic        resetn;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        idle_exec, periph_irq, ext_irq, wakeup_irq, prot;
  logic        core_output_clock, cpu_clk_en, sys_clk_en, watchdog_clock_en;
  logic        pll_on, osc_on, flash_pwr_on, osc_bypass;
  logic [5:0]  en;
  int          mismatches, n_compared, k;
  logic [31:0] q;
  assign en = {flash_pwr_on, osc_on, pll_on, watchdog_clock_en, sys_clk_en, cpu_clk_en};

  crlp_top #(.REF_DIV(8)) crlp_top_i (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .idle_exec(idle_exec), .periph_irq(periph_irq), .ext_irq(ext_irq), .wakeup_irq(wakeup_irq),
    .power_drive_protect_input(prot), .core_output_clock(core_output_clock), .cpu_clk_en(cpu_clk_en),
    .sys_clk_en(sys_clk_en), .watchdog_clock_en(watchdog_clock_en), .pll_on(pll_on), .osc_on(osc_on),
    .flash_pwr_on(flash_pwr_on), .osc_bypass(osc_bypass));
  crlp_cpu_model crlp_cpu_model_i (.ref_clk(ref_clk), .idle_exec(idle_exec), .periph_irq(periph_irq),
    .ext_irq(ext_irq), .wakeup_irq(wakeup_irq), .power_drive_protect_input(prot));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Holds the request until waitrequest is sampled low and takes read data at that same edge.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      close_out();
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic reset_vals();
    bus(0, 4'h0, 32'h0, 4'hF, q);
    chk("ctrl reset", q, 32'h0000_0E00);
    bus(0, 4'h4, 32'h0, 4'hF, q);
    chk("status reset", q, 32'h0000_00FC);
  endtask
  task automatic ratio_sweep();
    int exp_cnt[8] = '{840, 420, 280, 210, 168, 140, 120, 105};
    int cnt, c;
    for (c = 0; c < 8; c++) begin
      bus(1, 4'h0, {20'h0, c[2:0], 9'h0}, 4'hF, q);
      // Let the leftover accumulator of the previous ratio drain before counting.
      repeat (8) @(posedge ref_clk);
      cnt = 0;
      repeat (1680) @(posedge ref_clk) cnt += (core_output_clock === 1'b1);
      chk("ratio rate", (cnt >= exp_cnt[c] - 1 && cnt <= exp_cnt[c] + 1), 1'b1);
      bus(0, 4'h0, 32'h0, 4'hF, q);
      chk("ratio kept", q, {20'h0, c[2:0], 9'h0});
    end
  endtask
  // Each depth code is entered, refused by a source it must ignore, then woken by a valid one.
  task automatic sleep_case(input int i);
    logic [1:0] dep[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [5:0] xen[5] = '{6'h3E, 6'h3C, 6'h00, 6'h00, 6'h3E};
    logic [3:0] bad[5] = '{4'h4, 4'h1, 4'h7, 4'h7, 4'h4};
    logic [3:0] good[5] = '{4'h1, 4'h4, 4'h8, 4'h8, 4'h2};
    logic [1:0] st[5] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h1};
    logic [31:0] wd;
    int n, pc;
    wd = {18'h0, dep[i], 3'h7, 9'h0};
    bus(1, 4'h0, wd, 4'hF, q);
    crlp_cpu_model_i.issue_idle();
    @(negedge ref_clk);
    chk("sleep enables", en, xen[i]);
    crlp_cpu_model_i.set_wake(bad[i]);
    pc = 0;
    repeat (40) @(posedge ref_clk) pc += (core_output_clock === 1'b1);
    chk("ignored wake", en, xen[i]);
    chk("core clock runs", pc > 0, i < 2 || i == 4);
    bus(0, 4'h4, 32'h0, 4'hF, q);
    chk("sleep state", q[1:0], st[i]);
    crlp_cpu_model_i.set_wake(good[i]);
    for (n = 0; n < 12 && cpu_clk_en !== 1'b1; n++) @(posedge ref_clk);
    if (n >= 12) begin
      mismatches++;
      close_out();
    end
    @(negedge ref_clk);
    chk("woken", en, 6'h3F);
    crlp_cpu_model_i.set_wake(4'h0);
    bus(0, 4'h0, 32'h0, 4'hF, q);
    chk("ctrl across sleep", q, wd);
  endtask
  task automatic lane_and_map();
    bus(1, 4'h0, 32'h0000_0200, 4'hD, q);
    bus(1, 4'h8, 32'hFFFF_FFFF, 4'hF, q);
    bus(1, 4'h4, 32'h0000_0000, 4'hF, q);
    bus(0, 4'h0, 32'h0, 4'hF, q);
    chk("lane and map", q, 32'h0000_0E00);
    bus(0, 4'h8, 32'h0, 4'hF, q);
    chk("unmapped read", q, 32'h0);
  endtask
  task automatic bypass_case();
    bus(1, 4'h0, 32'h0000_0E01, 4'hF, q);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("bypass", {osc_bypass, osc_on}, 2'b10);
    bus(1, 4'h0, 32'h0000_2E00, 4'hF, q);
  endtask
  // Reset must wake the halt depth and clear the depth field back to zero.
  task automatic reset_wake();
    crlp_cpu_model_i.issue_idle();
    @(negedge ref_clk);
    chk("halt entered", en, 6'h00);
    @(posedge ref_clk) resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk("reset wakes", en, 6'h3F);
    bus(0, 4'h0, 32'h0, 4'hF, q);
    chk("ratio after reset", q, 32'h0000_0E00);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #300000;
    mismatches++;
    close_out();
  end
  initial begin
    resetn = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    reset_vals();
    ratio_sweep();
    for (k = 0; k < 5; k++) sleep_case(k);
    lane_and_map();
    bypass_case();
    reset_wake();
    close_out();
  end
endmodule
